/* core/i2c_queue_pkg.sv */
// constants, types and state encodings shared by the queued i2c master
// assumes one 100 MHz clock; bus rate and lock timeout are derived here
`default_nettype none
package i2c_queue_pkg;
  localparam int CLK_NS = 10;
  localparam int BIT_NS = 10000;
  localparam int QUARTER_CYC = BIT_NS / 4 / CLK_NS;
  localparam int LOCK_MS = 200;
  localparam int LOCK_CYC = LOCK_MS * 1000000 / CLK_NS;
  localparam int QDEPTH = 4;
  localparam logic [15:0] MAX_COUNT = 16'hFFFF;
  localparam logic [15:0] MAX_COUNT_TEN = 16'hFFFE;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
  localparam int STAT_DATA_NACK = 0;
  localparam int STAT_ADDR_NACK = 1;
  localparam int STAT_ARB_LOST = 2;
  localparam int STAT_BUS_LOCKED = 3;
  localparam logic [1:0] RESP_NONE = 2'h0;
  localparam logic [1:0] RESP_READ = 2'h1;
  localparam logic [1:0] RESP_WRITE = 2'h2;
  localparam logic [1:0] BK_ADDR = 2'h0;
  localparam logic [1:0] BK_ADDR_LOW = 2'h1;
  localparam logic [1:0] BK_ADDR_RD = 2'h2;
  localparam logic [1:0] BK_DATA = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_BYTE = 3'h3,
    ST_STOP = 3'h2,
    ST_DONE = 3'h6
  } bus_state_e;

  typedef struct packed {
    logic isRead;
    logic tenBit;
    logic [9:0] addr;
    logic [15:0] count;
    logic [15:0] bufLen;
    logic [15:0] doneCnt;
    logic [3:0] status;
  } entry_s;
endpackage : i2c_queue_pkg
`default_nettype wire

/* core/two_entry_buffer.sv */
// two-entry valid/ready buffer in the read data path
// assumes both sides on the same clock; producer stalls while inReady is low
`default_nettype none
module two_entry_buffer (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // filling side
  input wire logic inValid,
  input wire logic [7:0] inData,
  output logic inReady,
  // draining side
  output logic outValid,
  output logic [7:0] outData,
  input wire logic outReady
);
  typedef struct packed {
    logic [1:0][7:0] mem;
    logic rdIdx;
    logic wrIdx;
    logic [1:0] fill;
  } buf_s;

  buf_s q, d;

  assign inReady = (q.fill != 2'h2);
  assign outValid = (q.fill != 2'h0);
  assign outData = q.mem[q.rdIdx];

  always_comb
  begin
    logic push;
    logic pop;
    push = inValid && inReady;
    pop = outValid && outReady;
    d = q;
    if (push)
    begin
      d.mem[q.wrIdx] = inData;
      d.wrIdx = ~q.wrIdx;
    end
    if (pop)
      d.rdIdx = ~q.rdIdx;
    if (push && !pop)
      d.fill = q.fill + 2'h1;
    else if (pop && !push)
      d.fill = q.fill - 2'h1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end
endmodule : two_entry_buffer
`default_nettype wire

/* core/i2c_master_queue.sv */
// queued i2c master: command queue, bit engine, response store
// assumes open-drain pins resolved outside; host sees one clock domain
`default_nettype none
module i2c_master_queue #(
  parameter int LOCK_CYCLES = i2c_queue_pkg::LOCK_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // command queueing
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic cmdIsRead,
  input wire logic cmdTenBit,
  input wire logic [15:0] cmdAddr,
  input wire logic [15:0] cmdCount,
  input wire logic [15:0] cmdBufLen,
  // submission
  input wire logic submitBlocking,
  input wire logic submitAsync,
  output logic busy,
  output logic hostBlocked,
  output logic submitDone,
  // write data stream
  input wire logic wrValid,
  input wire logic [7:0] wrData,
  output logic wrReady,
  // read data stream
  output logic rdValid,
  output logic [7:0] rdData,
  input wire logic rdReady,
  // response fetch
  input wire logic fetchNext,
  input wire logic fetchRead,
  input wire logic fetchWrite,
  output logic respValid,
  output logic [1:0] respType,
  output logic [15:0] resultCount,
  output logic [3:0] resultStatus,
  output logic resultOk,
  output logic mismatchErr,
  // bus pins
  input wire logic sclIn,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOe
);
  typedef struct packed {
    i2c_queue_pkg::bus_state_e st;
    logic [1:0] ph;
    logic [7:0] div;
    logic [31:0] lock;
    logic sclMeta, sclSync, sdaMeta, sdaSync;
    logic sclOe, sdaOe;
    logic running, blocking, spent, done;
    logic [2:0] nQ, cur, resp;
    i2c_queue_pkg::entry_s [i2c_queue_pkg::QDEPTH-1:0] ent;
    logic [7:0] sh;
    logic [3:0] bitN;
    logic [1:0] bk;
    logic rx, lastRx, needData, pushPend;
    logic [7:0] pushData;
    logic [15:0] byteCnt;
    logic [3:0] stat;
    logic respValid;
    logic [1:0] respType;
    logic [15:0] respCnt;
    logic [3:0] respStat;
    logic [15:0] resultCount;
    logic [3:0] resultStatus;
    logic resultOk, mismatch;
  } state_s;

  state_s q, d;
  logic bufReady;

  two_entry_buffer rdBuf (
    .clk(clk),
    .rst(rst),
    .inValid(q.pushPend),
    .inData(q.pushData),
    .inReady(bufReady),
    .outValid(rdValid),
    .outData(rdData),
    .outReady(rdReady)
  );

  assign cmdReady = !q.running && (q.spent || q.nQ < 3'(i2c_queue_pkg::QDEPTH));
  assign busy = q.running;
  assign hostBlocked = q.running && q.blocking;
  assign submitDone = q.done;
  assign sclOe = q.sclOe;
  assign sdaOe = q.sdaOe;
  assign respValid = q.respValid;
  assign respType = q.respType;
  assign resultCount = q.resultCount;
  assign resultStatus = q.resultStatus;
  assign resultOk = q.resultOk;
  assign mismatchErr = q.mismatch;
  // data is taken at the first quarter of a data byte, only while one is wanted
  assign wrReady = (q.st == i2c_queue_pkg::ST_BYTE) && q.needData && q.ph == 2'h0 && q.bitN == 4'h0
    && q.div == 8'(i2c_queue_pkg::QUARTER_CYC - 1);

  always_comb
  begin
    logic tick;
    logic event_;
    logic want;
    logic [7:0] bits;
    i2c_queue_pkg::entry_s e;
    logic [2:0] slot;
    tick = 1'b0;
    event_ = 1'b0;
    want = 1'b0;
    bits = q.sh;
    e = q.ent[q.cur[1:0]];
    slot = '0;
    d = q;
    d.done = 1'b0;
    d.resultOk = 1'b0;
    d.mismatch = 1'b0;
    d.sclMeta = sclIn;
    d.sclSync = q.sclMeta;
    d.sdaMeta = sdaIn;
    d.sdaSync = q.sdaMeta;
    if (q.pushPend && bufReady)
      d.pushPend = 1'b0;
    // bus steps advance at four quarters per bit
    if (q.st == i2c_queue_pkg::ST_IDLE || q.div == 8'(i2c_queue_pkg::QUARTER_CYC - 1))
    begin
      d.div = '0;
      tick = (q.st != i2c_queue_pkg::ST_IDLE);
    end
    else
      d.div = q.div + 8'h1;

    // host side only acts between submissions
    if (!q.running)
    begin
      if (cmdValid && cmdReady)
      begin
        slot = q.spent ? 3'h0 : q.nQ;
        d.ent[slot[1:0]] = '0;
        d.ent[slot[1:0]].isRead = cmdIsRead;
        d.ent[slot[1:0]].tenBit = cmdTenBit;
        d.ent[slot[1:0]].addr = cmdTenBit ? cmdAddr[9:0] : {3'h0, cmdAddr[6:0]};
        d.ent[slot[1:0]].count = cmdCount;
        if (cmdTenBit && !cmdIsRead && cmdCount == i2c_queue_pkg::MAX_COUNT)
          d.ent[slot[1:0]].count = i2c_queue_pkg::MAX_COUNT_TEN;
        d.ent[slot[1:0]].bufLen = cmdBufLen;
        d.nQ = slot + 3'h1;
        d.spent = 1'b0;
        d.resp = '0;
        d.respValid = 1'b0;
        d.respType = i2c_queue_pkg::RESP_NONE;
      end
      else if ((submitBlocking || submitAsync) && !q.spent && q.nQ != 3'h0)
      begin
        d.running = 1'b1;
        d.blocking = submitBlocking;
        d.cur = '0;
      end
      else if (fetchNext)
      begin
        // previous result is dropped here and when a command is queued
        if (q.spent && q.resp < q.nQ)
        begin
          d.respValid = 1'b1;
          d.respType = q.ent[q.resp[1:0]].isRead ? i2c_queue_pkg::RESP_READ : i2c_queue_pkg::RESP_WRITE;
          d.respCnt = q.ent[q.resp[1:0]].doneCnt;
          d.respStat = q.ent[q.resp[1:0]].status;
          d.resp = q.resp + 3'h1;
        end
        else
        begin
          d.respValid = 1'b0;
          d.respType = i2c_queue_pkg::RESP_NONE;
        end
      end
      else if (fetchRead || fetchWrite)
      begin
        if (q.respValid && (fetchRead ? q.respType == i2c_queue_pkg::RESP_READ
                                      : q.respType == i2c_queue_pkg::RESP_WRITE))
        begin
          d.resultOk = 1'b1;
          d.resultCount = q.respCnt;
          d.resultStatus = q.respStat;
        end
        else
          d.mismatch = 1'b1;
      end
    end

    case (q.st)
      i2c_queue_pkg::ST_IDLE:
      begin
        d.lock = '0;
        if (q.running)
        begin
          d.st = i2c_queue_pkg::ST_START;
          d.ph = '0;
          d.bk = i2c_queue_pkg::BK_ADDR;
          d.byteCnt = '0;
          d.stat = '0;
          d.rx = 1'b0;
          d.needData = 1'b0;
        end
      end
      i2c_queue_pkg::ST_START:
        if (tick)
        begin
          case (q.ph)
            2'h0: begin d.sdaOe = 1'b0; d.ph = 2'h1; end
            2'h1: begin d.sclOe = 1'b0; d.ph = 2'h2; end
            2'h2:
              if (q.sclSync)
              begin
                d.sdaOe = 1'b1;
                d.ph = 2'h3;
              end
            default:
            begin
              d.sclOe = 1'b1;
              d.ph = 2'h0;
              event_ = 1'b1;
              d.st = i2c_queue_pkg::ST_BYTE;
              d.bitN = '0;
              d.rx = 1'b0;
              // address byte exists only once the start is on the bus
              if (q.bk == i2c_queue_pkg::BK_ADDR_RD)
                d.sh = {i2c_queue_pkg::TEN_BIT_PREFIX, e.addr[9:8], 1'b1};
              else if (e.tenBit)
                d.sh = {i2c_queue_pkg::TEN_BIT_PREFIX, e.addr[9:8], 1'b0};
              else
                d.sh = {e.addr[6:0], e.isRead};
            end
          endcase
        end
      i2c_queue_pkg::ST_BYTE:
        if (tick)
        begin
          case (q.ph)
            2'h0:
              if (!(q.bitN == 4'h0 && ((q.needData && !wrValid) || q.pushPend)))
              begin
                if (q.bitN == 4'h0 && q.needData)
                begin
                  bits = wrData;
                  d.sh = wrData;
                  d.needData = 1'b0;
                end
                if (q.rx)
                  d.sdaOe = (q.bitN == 4'h8) ? !q.lastRx : 1'b0;
                else
                  d.sdaOe = (q.bitN == 4'h8) ? 1'b0 : !bits[7];
                d.ph = 2'h1;
              end
            2'h1: begin d.sclOe = 1'b0; d.ph = 2'h2; end
            2'h2:
              if (q.sclSync)
              begin
                d.ph = 2'h3;
                if (!q.rx && q.bitN != 4'h8 && !q.sdaOe && !q.sdaSync)
                begin
                  // another master holds data low: back off without driving
                  d.stat[i2c_queue_pkg::STAT_ARB_LOST] = 1'b1;
                  d.sdaOe = 1'b0;
                  d.st = i2c_queue_pkg::ST_DONE;
                end
                else if (q.rx && q.bitN != 4'h8)
                  d.sh = {q.sh[6:0], q.sdaSync};
                else if (!q.rx && q.bitN == 4'h8)
                  d.sh[0] = !q.sdaSync;
              end
            default:
            begin
              d.sclOe = 1'b1;
              d.ph = 2'h0;
              if (q.bitN != 4'h8)
              begin
                d.bitN = q.bitN + 4'h1;
                if (!q.rx)
                  d.sh = {q.sh[6:0], 1'b0};
              end
              else
              begin
                event_ = 1'b1;
                d.bitN = '0;
                want = q.sh[0];
                if (q.bk != i2c_queue_pkg::BK_DATA && !want)
                begin
                  d.stat[i2c_queue_pkg::STAT_ADDR_NACK] = 1'b1;
                  d.st = i2c_queue_pkg::ST_STOP;
                end
                else if (q.bk == i2c_queue_pkg::BK_ADDR && e.tenBit)
                begin
                  d.bk = i2c_queue_pkg::BK_ADDR_LOW;
                  d.sh = e.addr[7:0];
                end
                else if (q.bk == i2c_queue_pkg::BK_ADDR_LOW && e.isRead)
                begin
                  d.bk = i2c_queue_pkg::BK_ADDR_RD;
                  d.st = i2c_queue_pkg::ST_START;
                end
                else if (q.bk != i2c_queue_pkg::BK_DATA)
                begin
                  d.bk = i2c_queue_pkg::BK_DATA;
                  if (e.isRead)
                  begin
                    d.rx = 1'b1;
                    d.lastRx = (e.count <= 16'h0001);
                  end
                  else if (e.count == 16'h0000)
                    d.st = i2c_queue_pkg::ST_STOP;
                  else
                    d.needData = 1'b1;
                end
                else if (!q.rx)
                begin
                  d.byteCnt = q.byteCnt + 16'h1;
                  if (!want && q.byteCnt + 16'h1 == e.count)
                    d.stat[i2c_queue_pkg::STAT_DATA_NACK] = 1'b1;
                  if (!want || q.byteCnt + 16'h1 == e.count)
                    d.st = i2c_queue_pkg::ST_STOP;
                  else
                    d.needData = 1'b1;
                end
                else
                begin
                  // the forced byte of an empty read never reaches the host
                  if (e.count != 16'h0000)
                  begin
                    d.byteCnt = q.byteCnt + 16'h1;
                    d.pushPend = (q.byteCnt < e.bufLen);
                    d.pushData = q.sh;
                  end
                  if (q.lastRx)
                    d.st = i2c_queue_pkg::ST_STOP;
                  else
                    d.lastRx = (q.byteCnt + 16'h2 == e.count);
                end
              end
            end
          endcase
        end
      i2c_queue_pkg::ST_STOP:
        if (tick)
        begin
          case (q.ph)
            2'h0: begin d.sdaOe = 1'b1; d.ph = 2'h1; end
            2'h1: begin d.sclOe = 1'b0; d.ph = 2'h2; end
            2'h2:
              if (q.sclSync)
                d.ph = 2'h3;
            default:
            begin
              d.sdaOe = 1'b0;
              d.ph = 2'h0;
              event_ = 1'b1;
              d.st = i2c_queue_pkg::ST_DONE;
            end
          endcase
        end
      i2c_queue_pkg::ST_DONE:
      begin
        d.sclOe = 1'b0;
        d.sdaOe = 1'b0;
        d.ent[q.cur[1:0]].doneCnt = (q.stat[i2c_queue_pkg::STAT_ADDR_NACK] ||
          (q.stat[i2c_queue_pkg::STAT_ARB_LOST] && q.bk != i2c_queue_pkg::BK_DATA)) ? 16'h0000 : q.byteCnt;
        d.ent[q.cur[1:0]].status = q.stat;
        d.cur = q.cur + 3'h1;
        d.st = i2c_queue_pkg::ST_IDLE;
        if (q.cur + 3'h1 == q.nQ)
        begin
          d.running = 1'b0;
          d.spent = 1'b1;
          d.done = 1'b1;
        end
      end
      default: d.st = i2c_queue_pkg::ST_IDLE;
    endcase

    // a wedged bus cannot be stopped cleanly, so the lines are simply released
    if (q.st != i2c_queue_pkg::ST_IDLE && q.st != i2c_queue_pkg::ST_DONE)
    begin
      if (event_)
        d.lock = '0;
      else if (q.lock >= 32'(LOCK_CYCLES - 1))
      begin
        d.stat[i2c_queue_pkg::STAT_BUS_LOCKED] = 1'b1;
        d.st = i2c_queue_pkg::ST_DONE;
      end
      else
        d.lock = q.lock + 32'h1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end
endmodule : i2c_master_queue
`default_nettype wire

/* tb/i2c_master_queue_chk.sv */
// port assertions for the queued i2c master
// bound to the top module from the bench; one clock domain
`default_nettype none
module i2c_master_queue_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host side
  input wire logic cmdValid,
  input wire logic submitBlocking,
  input wire logic submitAsync,
  input wire logic busy,
  input wire logic hostBlocked,
  input wire logic submitDone,
  input wire logic wrReady,
  input wire logic fetchNext,
  input wire logic fetchRead,
  input wire logic fetchWrite,
  input wire logic [1:0] respType,
  input wire logic resultOk,
  input wire logic mismatchErr,
  input wire logic [3:0] resultStatus,
  // bus pins
  input wire logic sclIn,
  input wire logic sclOe,
  input wire logic sdaIn,
  input wire logic sdaOe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  logic fetchOnly;
  // result fetches lose to queueing, submission and next-response in the same cycle
  assign fetchOnly = !busy && !cmdValid && !submitBlocking && !submitAsync && !fetchNext;
  AST_RUN_ON_SUBMIT: assert property ($rose(busy) |-> $past(submitBlocking || submitAsync))
    else $error("busy rose without a submit pulse");
  AST_QUIET_IDLE: assert property (!busy && !$past(busy) |-> !sclOe && !sdaOe)
    else $error("bus driven while idle");
  AST_BLOCKED_BUSY: assert property (hostBlocked |-> busy)
    else $error("host blocked without a running batch");
  AST_DONE_PULSE: assert property (submitDone |=> !submitDone)
    else $error("done pulse longer than one cycle");
  AST_START_OWNED: assert property (sclIn && $past(sclIn) && $fell(sdaIn) |-> busy)
    else $error("start condition outside a batch");
  AST_STOP_OWNED: assert property (sclIn && $past(sclIn) && $rose(sdaIn) |-> busy)
    else $error("stop condition outside a batch");
  AST_EXCLUSIVE: assert property (!(resultOk && mismatchErr))
    else $error("result accepted and refused together");
  AST_MISMATCH_READ: assert property (fetchOnly && fetchRead && !fetchWrite &&
    respType != i2c_queue_pkg::RESP_READ |=> mismatchErr)
    else $error("wrong-type read fetch not refused");
  AST_READ_OK: assert property (fetchOnly && fetchRead && !fetchWrite &&
    respType == i2c_queue_pkg::RESP_READ |=> resultOk && !mismatchErr)
    else $error("read fetch not accepted");
  AST_WRITE_OK: assert property (fetchOnly && fetchWrite && !fetchRead &&
    respType == i2c_queue_pkg::RESP_WRITE |=> resultOk && !mismatchErr)
    else $error("write fetch not accepted");
  AST_NO_WRITE_IDLE: assert property (wrReady |-> busy)
    else $error("write data taken while idle");
  cover property (submitDone);
  cover property (mismatchErr);
  cover property (resultOk && resultStatus[0]);
endmodule : i2c_master_queue_chk
`default_nettype wire

/* tb/i2c_slave_model.sv */
// behavioural i2c slave at one seven-bit address
// assumes the bench resolves open-drain wires with pull-ups
`default_nettype none
module i2c_slave_model #(
  parameter logic [6:0] OWN_ADDR = 7'h2A
) (
  // bus wires
  input wire logic scl,
  input wire logic sda,
  output logic sclOe,
  output logic sdaOe,
  // behaviour
  input wire logic [7:0] nackAt,
  input wire logic [7:0] readBase,
  input wire logic slow,
  // observation
  output logic [7:0] rxCount,
  output logic [7:0] rxLast,
  output logic [7:0] adrLast
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sr;
  logic [7:0] k;
  initial
  begin
    sclOe = 1'b0;
    sdaOe = 1'b0;
    rxCount = 8'h00;
    rxLast = 8'h00;
    adrLast = 8'h00;
  end
  // a stop aborts any frame, stretch included, so nothing stays held
  always @(posedge sda)
  begin
    if (scl === 1'b1)
    begin
      disable frame;
      sdaOe = 1'b0;
      sclOe = 1'b0;
    end
  end
  task automatic getByte();
    repeat (8)
    begin
      @(posedge scl);
      sr = {sr[6:0], sda};
    end
  endtask : getByte
  task automatic ack(input logic ok);
    @(negedge scl);
    sdaOe = ok;
    if (slow)
    begin
      // held past the master's high-phase check, so it really has to wait
      sclOe = 1'b1;
      #9000;
      sclOe = 1'b0;
    end
    @(negedge scl);
    sdaOe = 1'b0;
  endtask : ack
  task automatic sendBytes();
    logic [7:0] v;
    v = readBase;
    forever
    begin
      for (int i = 7; i >= 0; i--)
      begin
        sdaOe = !v[i];
        @(negedge scl);
      end
      sdaOe = 1'b0;
      @(posedge scl);
      if (sda === 1'b1)
        wait (1'b0);
      @(negedge scl);
      v = v + 8'h01;
    end
  endtask : sendBytes
  initial
    forever
    begin : frame
      @(negedge sda iff scl === 1'b1);
      k = 8'h00;
      getByte();
      adrLast = sr;
      if (sr[7:1] !== OWN_ADDR)
        wait (1'b0);
      ack(1'b1);
      if (sr[0])
        sendBytes();
      forever
      begin
        getByte();
        k = k + 8'h01;
        rxCount = rxCount + 8'h01;
        rxLast = sr;
        ack(k != nackAt);
      end
    end
endmodule : i2c_slave_model
`default_nettype wire

/* tb/i2c_master_queue_bench.sv */
// self-checking bench for the queued i2c master with one slave model
// assumes a 100 MHz clock and a short lock timeout
`default_nettype none
module i2c_master_queue_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, cmdValid, cmdIsRead, cmdTenBit, submitBlocking, submitAsync, wrValid, rdReady;
  logic fetchNext, fetchRead, fetchWrite, took, slow, cmdReady, busy, hostBlocked, submitDone;
  logic wrReady, rdValid, respValid, resultOk, mismatchErr, sclOe, sdaOe, slvSclOe, slvSdaOe;
  logic [15:0] cmdAddr, cmdCount, cmdBufLen, resultCount;
  logic [7:0] rdData, rxCount, rxLast, adrLast;
  logic [7:0] wrData = 8'hC3;
  logic [7:0] rdSeen = 8'h00;
  logic [7:0] rdLast = 8'h00;
  logic [1:0] respType;
  logic [3:0] resultStatus;
  logic sclLine, sdaLine;
  int miscompares = 0;
  int checks = 0;
  assign sclLine = ~(sclOe | slvSclOe);
  assign sdaLine = ~(sdaOe | slvSdaOe);
  i2c_master_queue #(.LOCK_CYCLES(20000)) DUT (.clk(clk), .rst(rst), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdIsRead(cmdIsRead), .cmdTenBit(cmdTenBit), .cmdAddr(cmdAddr),
    .cmdCount(cmdCount), .cmdBufLen(cmdBufLen), .submitBlocking(submitBlocking),
    .submitAsync(submitAsync), .busy(busy), .hostBlocked(hostBlocked), .submitDone(submitDone),
    .wrValid(wrValid), .wrData(wrData), .wrReady(wrReady), .rdValid(rdValid), .rdData(rdData),
    .rdReady(rdReady), .fetchNext(fetchNext), .fetchRead(fetchRead), .fetchWrite(fetchWrite),
    .respValid(respValid), .respType(respType), .resultCount(resultCount),
    .resultStatus(resultStatus), .resultOk(resultOk), .mismatchErr(mismatchErr),
    .sclIn(sclLine), .sclOe(sclOe), .sdaIn(sdaLine), .sdaOe(sdaOe));
  i2c_slave_model SLV (.scl(sclLine), .sda(sdaLine), .sclOe(slvSclOe), .sdaOe(slvSdaOe),
    .nackAt(8'h02), .readBase(8'h5E), .slow(slow), .rxCount(rxCount), .rxLast(rxLast), .adrLast(adrLast));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // each accepted write byte advances the stream so byte order shows on the wire
  always @(posedge clk) took <= wrValid && wrReady;
  always @(negedge clk) if (took) wrData <= wrData + 8'h11;
  always @(posedge clk)
  begin
    if (rdValid && rdReady)
    begin
      rdSeen <= rdSeen + 8'h01;
      rdLast <= rdData;
    end
  end
  task automatic final_report();
    if (miscompares == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic compare(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare
  task automatic waitFor(input logic pickRd);
    int n;
    for (n = 0; n < 90000 && (pickRd ? rdValid : submitDone) !== 1'b1; n++)
      @(negedge clk);
    if (n == 90000)
    begin
      miscompares++;
      final_report();
    end
  endtask : waitFor
  task automatic queueCmd(input logic rd, input logic [15:0] addr, input logic [15:0] cnt,
    input logic [15:0] len);
    @(negedge clk);
    cmdValid = 1'b1;
    cmdIsRead = rd;
    cmdAddr = addr;
    cmdCount = cnt;
    cmdBufLen = len;
    compare(cmdReady, 16'h0001);
    @(negedge clk);
    cmdValid = 1'b0;
  endtask : queueCmd
  task automatic submit(input logic blk);
    @(negedge clk);
    submitBlocking = blk;
    submitAsync = !blk;
    @(negedge clk);
    submitBlocking = 1'b0;
    submitAsync = 1'b0;
    compare(busy, 16'h0001);
    compare(hostBlocked, blk);
  endtask : submit
  task automatic pulse(input logic [2:0] f);
    @(negedge clk);
    {fetchNext, fetchRead, fetchWrite} = f;
    @(negedge clk);
    {fetchNext, fetchRead, fetchWrite} = 3'b000;
  endtask : pulse
  task automatic fetchResp(input logic [1:0] typ, input logic [15:0] cnt, input logic [3:0] stat);
    pulse(3'b100);
    compare(respType, typ);
    compare(respValid, typ != i2c_queue_pkg::RESP_NONE);
    pulse(typ == i2c_queue_pkg::RESP_READ ? 3'b001 : 3'b010);
    compare(mismatchErr, 16'h0001);
    if (typ != i2c_queue_pkg::RESP_NONE)
      repeat (2)
      begin
        pulse(typ == i2c_queue_pkg::RESP_READ ? 3'b010 : 3'b001);
        compare(resultOk, 16'h0001);
        compare(resultCount, cnt);
        compare(resultStatus, stat);
      end
  endtask : fetchResp
  task automatic writeBatch();
    slow = 1'b1;
    queueCmd(1'b0, 16'hFF2A, 16'h0002, 16'h0000);
    queueCmd(1'b0, 16'h002A, 16'h0000, 16'h0000);
    cmdTenBit = 1'b1;
    queueCmd(1'b0, 16'h0311, 16'h0001, 16'h0000);
    cmdTenBit = 1'b0;
    repeat (40) @(negedge clk);
    compare({busy, sclOe, sdaOe}, 16'h0000);
    submit(1'b1);
    waitFor(1'b0);
    repeat (2) @(negedge clk);
    compare(rxCount, 16'h0002);
    compare(rxLast, 16'h00D4);
    compare(adrLast, 16'h00F6);
    fetchResp(i2c_queue_pkg::RESP_WRITE, 16'h0002, 4'h1);
    fetchResp(i2c_queue_pkg::RESP_WRITE, 16'h0000, 4'h0);
    fetchResp(i2c_queue_pkg::RESP_WRITE, 16'h0000, 4'h2);
    fetchResp(i2c_queue_pkg::RESP_NONE, 16'h0000, 4'h0);
  endtask : writeBatch
  task automatic readBatch();
    slow = 1'b0;
    queueCmd(1'b1, 16'h002A, 16'h0003, 16'h0002);
    submit(1'b0);
    waitFor(1'b1);
    compare(rdData, 16'h005E);
    // hold the reader off until both buffer entries are full
    repeat (12000) @(negedge clk);
    rdReady = 1'b1;
    waitFor(1'b0);
    repeat (2) @(negedge clk);
    compare(rdSeen, 16'h0002);
    compare(rdLast, 16'h005F);
    compare(adrLast, 16'h0055);
    fetchResp(i2c_queue_pkg::RESP_READ, 16'h0003, 4'h0);
  endtask : readBatch
  initial
  begin
    rst = 1'b1;
    {cmdValid, cmdIsRead, cmdTenBit, submitBlocking, submitAsync, rdReady, slow} = 7'h00;
    {fetchNext, fetchRead, fetchWrite} = 3'b000;
    {cmdAddr, cmdCount, cmdBufLen} = 48'h0;
    wrValid = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    writeBatch();
    readBatch();
    final_report();
  end
endmodule : i2c_master_queue_bench
bind i2c_master_queue i2c_master_queue_chk CHK (.clk(clk), .rst(rst), .cmdValid(cmdValid),
  .submitBlocking(submitBlocking), .submitAsync(submitAsync), .busy(busy), .hostBlocked(hostBlocked),
  .submitDone(submitDone), .wrReady(wrReady), .fetchNext(fetchNext), .fetchRead(fetchRead),
  .fetchWrite(fetchWrite), .respType(respType), .resultOk(resultOk), .mismatchErr(mismatchErr),
  .resultStatus(resultStatus), .sclIn(sclIn), .sclOe(sclOe), .sdaIn(sdaIn), .sdaOe(sdaOe));
`default_nettype wire
